// [src/adc_ctrl_pkg.sv]
// Purpose: Shared constants for the converter control block
// Assumes: APB with 32-bit data, word-aligned registers
// Notes: Conversion timing counted in half conversion-clock periods
package adc_ctrl_pkg;
  // Register byte offsets
  localparam logic [4:0] OFF_CTRL0 = 5'h00;
  localparam logic [4:0] OFF_CTRL2 = 5'h04;
  localparam logic [4:0] OFF_CLKCFG = 5'h08;
  localparam logic [4:0] OFF_RES_HI = 5'h0C;
  localparam logic [4:0] OFF_RES_LO = 5'h10;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFF_IRQ_EN = 5'h18;
  localparam logic [4:0] OFF_IRQ_CLR = 5'h1C;
  // Field positions
  localparam int ON_BIT = 0;
  localparam int GO_BIT = 1;
  localparam int CHAN_LSB = 2;
  localparam int TRIG_LSB = 4;
  localparam int RC_BIT = 0;
  // Reset values
  localparam logic [4:0] CHAN_RST = 5'h00;
  localparam logic [2:0] TRIG_RST = 3'h0;
  localparam logic [9:0] RESULT_RST = 10'h000;
  // Trigger select codes; 001 and 010 are reserved
  localparam logic [2:0] TRIG_NONE = 3'h0;
  localparam logic [2:0] TRIG_TIMER_ZERO = 3'h3;
  localparam logic [2:0] TRIG_TIMER_ONE = 3'h4;
  localparam logic [2:0] TRIG_TIMER_TWO = 3'h5;
  localparam logic [2:0] TRIG_CMP1 = 3'h6;
  localparam logic [2:0] TRIG_CMP2 = 3'h7;
  // Channel codes
  localparam logic [4:0] CHAN_EXT_FIRST = 5'h03;
  localparam logic [4:0] CHAN_EXT_LAST = 5'h0B;
  localparam logic [4:0] CHAN_TEMP = 5'h1D;
  localparam logic [4:0] CHAN_DAC = 5'h1E;
  localparam logic [4:0] CHAN_FIXREF = 5'h1F;
  // Interrupt status bits: done, then one per trigger source
  localparam int NUM_IRQ = 6;
  localparam int IRQ_DONE = 0;
  // Timing counts in pclk cycles or half conversion-clock periods
  localparam int SYS_HALF_TAD_CYCLES = 2;
  localparam int INSTR_CYCLES = 4;
  localparam int CONV_HALF_TADS = 23;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} conv_state_t;
endpackage

// [src/adc_conversion_control.sv]
// Purpose: Converter control sequencing with APB registers
// Assumes: rc_tick pulses once per half RC conversion-clock period
// Notes: Result is right justified; reads of clear register give zero
// Functional notes
// - Converter works only while module_on is set
// - Writing go bit 1 starts a conversion on the selected channel
// - Completion clears go, sets done flag, loads result registers
// - Clearing go aborts; partial result, unresolved bits copy last resolved
// - Reset returns all registers to reset values, cancelling conversion
// - RC clock mode delays conversion start by one instruction cycle
// - RC mode sleep: completion wakes if enabled, else module shuts off
// - Non-RC clock: sleep aborts conversion and shuts module off
// - Rising edge of selected trigger source sets go bit
// - Three-bit trigger_select field picks timer or comparator source
// - Each trigger source edge sets its own interrupt flag
// - Conversion takes 11.5 conversion-clock periods
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
module adc_conversion_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] trig_src,
  input wire logic rc_tick,
  input wire logic sleep_mode,
  input wire logic cmp_above,
  output logic [9:0] trial_code,
  output logic [4:0] channel_code,
  output logic channel_connected,
  output logic analog_enable,
  output logic irq,
  output logic wake_req
);
  import adc_ctrl_pkg::*;

  // Channel map; unlisted codes connect nothing
  function automatic logic chan_valid(input logic [4:0] c);
    return (c >= CHAN_EXT_FIRST && c <= CHAN_EXT_LAST) ||
           c == CHAN_TEMP || c == CHAN_DAC || c == CHAN_FIXREF;
  endfunction

  // Trigger source picked by select code, reserved codes give none
  function automatic logic trig_pick(input logic [2:0] s, input logic [4:0] e);
    unique case (s)
      TRIG_TIMER_ZERO: return e[0];
      TRIG_TIMER_ONE: return e[1];
      TRIG_TIMER_TWO: return e[2];
      TRIG_CMP1: return e[3];
      TRIG_CMP2: return e[4];
      default: return 1'b0;
    endcase
  endfunction

  conv_state_t state_r, state_nxt;
  logic on_r, go_r, go_nxt, rc_sel_r, shut_r, shut_nxt;
  logic [4:0] chan_r;
  logic [2:0] trig_sel_r;
  logic [9:0] result_r, sar_r, mask_r, ptr_r, partial;
  logic last_r;
  logic [4:0] hcnt_r, prev_r;
  logic [1:0] div_r;
  logic [2:0] dly_r;
  logic [NUM_IRQ-1:0] stat_r, en_r, events;
  logic [31:0] rdata;

  // APB decode; zero-wait access phase, data latched in setup
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite;
  wire addr_ok = (paddr[1:0] == 2'h0);
  wire wr_ctrl0 = apb_wr && paddr == OFF_CTRL0;
  wire wr_ctrl2 = apb_wr && paddr == OFF_CTRL2;
  wire wr_clk = apb_wr && paddr == OFF_CLKCFG;
  wire wr_en = apb_wr && paddr == OFF_IRQ_EN;
  wire wr_clr = apb_wr && paddr == OFF_IRQ_CLR;
  assign pready = penable;
  assign pslverr = psel && penable && !addr_ok;

  // Conversion clock: RC ticks or divided pclk
  wire sys_tick = (div_r == 2'(SYS_HALF_TAD_CYCLES - 1));
  wire half_tick = rc_sel_r ? rc_tick : sys_tick;
  wire busy = state_r != ST_IDLE;

  // Trigger edges and start or stop causes
  wire [4:0] trig_edge = trig_src & ~prev_r;
  wire trig_start = on_r && trig_pick(trig_sel_r, trig_edge);
  wire sw_go = wr_ctrl0 && pwdata[GO_BIT] && on_r;
  wire sw_abort = wr_ctrl0 && !pwdata[GO_BIT] && go_r;
  wire sleep_abort = sleep_mode && !rc_sel_r && busy;
  wire turn_off = wr_ctrl0 && !pwdata[ON_BIT];
  wire any_stop = sw_abort || sleep_abort || turn_off || !on_r;
  wire start = (sw_go || trig_start) && !busy && !shut_r && !(sleep_mode && !rc_sel_r);
  wire in_conv = state_r == ST_CONV;
  wire resolve = in_conv && half_tick && ptr_r != 10'h000 && hcnt_r >= 5'h02 && !hcnt_r[0];
  wire done = in_conv && half_tick && hcnt_r == 5'(CONV_HALF_TADS - 1) && !any_stop;
  wire dly_done = dly_r == 3'(INSTR_CYCLES - 1);

  // Partial result: unresolved bits follow the last resolved bit
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_part
      assign partial[gi] = mask_r[gi] ? sar_r[gi] : last_r;
    end
  endgenerate

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    go_nxt = go_r;
    unique case (state_r)
      ST_IDLE: if (start) begin
        state_nxt = rc_sel_r ? ST_DELAY : ST_CONV;
        go_nxt = 1'b1;
      end
      ST_DELAY: if (dly_done) begin
        state_nxt = ST_CONV;
      end
      ST_CONV: if (done) begin
        state_nxt = ST_IDLE;
        go_nxt = 1'b0;
      end
    endcase
    if (busy && any_stop) begin
      state_nxt = ST_IDLE;
      go_nxt = 1'b0;
    end
  end

  // Sleep shutdown leaves module_on set; cleared on wake
  always_comb begin
    shut_nxt = shut_r;
    if (sleep_abort) begin
      shut_nxt = 1'b1;
    end else if (done && sleep_mode && rc_sel_r && !en_r[IRQ_DONE]) begin
      shut_nxt = 1'b1;
    end else if (!sleep_mode) begin
      shut_nxt = 1'b0;
    end
  end

  // Control registers; async reset clears everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      go_r <= 1'b0;
      on_r <= 1'b0;
      shut_r <= 1'b0;
      chan_r <= CHAN_RST;
      trig_sel_r <= TRIG_RST;
      rc_sel_r <= 1'b0;
      en_r <= '0;
      prev_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      go_r <= go_nxt;
      shut_r <= shut_nxt;
      prev_r <= trig_src;
      if (wr_ctrl0) begin
        on_r <= pwdata[ON_BIT];
        chan_r <= pwdata[CHAN_LSB +: 5];
      end
      if (wr_ctrl2) begin
        trig_sel_r <= pwdata[TRIG_LSB +: 3];
      end
      if (wr_clk) begin
        rc_sel_r <= pwdata[RC_BIT];
      end
      if (wr_en) begin
        en_r <= pwdata[NUM_IRQ-1:0];
      end
    end
  end

  // Timing counters; divider runs only while converting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      dly_r <= 3'h0;
      hcnt_r <= 5'h00;
    end else begin
      div_r <= (!in_conv || sys_tick) ? 2'h0 : div_r + 2'h1;
      dly_r <= (state_r == ST_DELAY) ? dly_r + 3'h1 : 3'h0;
      if (!in_conv) begin
        hcnt_r <= 5'h00;
      end else if (half_tick) begin
        hcnt_r <= hcnt_r + 5'h01;
      end
    end
  end

  // Successive approximation and result load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_r <= 10'h000;
      mask_r <= 10'h000;
      ptr_r <= 10'h000;
      last_r <= 1'b0;
      result_r <= RESULT_RST;
    end else begin
      if (start) begin
        sar_r <= 10'h200;
        ptr_r <= 10'h200;
        mask_r <= 10'h000;
        last_r <= 1'b0;
      end else if (resolve) begin
        sar_r <= (sar_r & ~ptr_r) | (cmp_above ? ptr_r : 10'h000) | (ptr_r >> 1);
        mask_r <= mask_r | ptr_r;
        last_r <= cmp_above;
        ptr_r <= ptr_r >> 1;
      end
      if (done) begin
        result_r <= sar_r;
      end else if (in_conv && sw_abort) begin
        result_r <= partial;
      end
    end
  end

  // Sticky interrupt status; set wins over clear
  assign events = {trig_edge, done};
  generate
    for (gi = 0; gi < NUM_IRQ; gi++) begin : g_stat
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stat_r[gi] <= 1'b0;
        end else if (events[gi]) begin
          stat_r[gi] <= 1'b1;
        end else if (wr_clr && pwdata[gi]) begin
          stat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Read mux; reserved bits and clear register read zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (paddr)
      OFF_CTRL0: rdata[6:0] = {chan_r, go_r, on_r};
      OFF_CTRL2: rdata[6:4] = trig_sel_r;
      OFF_CLKCFG: rdata[RC_BIT] = rc_sel_r;
      OFF_RES_HI: rdata[1:0] = result_r[9:8];
      OFF_RES_LO: rdata[7:0] = result_r[7:0];
      OFF_IRQ_STAT: rdata[NUM_IRQ-1:0] = stat_r;
      OFF_IRQ_EN: rdata[NUM_IRQ-1:0] = en_r;
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Registered read data and analog-side outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      trial_code <= 10'h000;
      channel_code <= CHAN_RST;
      channel_connected <= 1'b0;
      analog_enable <= 1'b0;
      irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      if (apb_setup) begin
        prdata <= rdata;
      end
      trial_code <= sar_r;
      channel_code <= chan_r;
      channel_connected <= chan_valid(chan_r);
      analog_enable <= on_r && !shut_r;
      irq <= |(stat_r & en_r);
      wake_req <= sleep_mode && stat_r[IRQ_DONE] && en_r[IRQ_DONE];
    end
  end

  // Checks
  localparam int CONV_CYC = CONV_HALF_TADS * SYS_HALF_TAD_CYCLES;
  logic [7:0] conv_cyc;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cyc <= 8'h00;
    end else begin
      conv_cyc <= in_conv ? conv_cyc + 8'h01 : 8'h00;
    end
  end

  AST_OFF_NO_GO: assert property (@(posedge pclk) disable iff (!presetn)
    !on_r |=> !go_r) else $error("go set while module off");
  AST_GO_START: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> go_r && state_r != ST_IDLE) else $error("go write did not start");
  AST_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    done |=> !go_r && stat_r[IRQ_DONE] && result_r == $past(sar_r)) else $error("completion wrong");
  AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
    in_conv && sw_abort |=> !go_r && result_r == $past(partial)) else $error("abort result wrong");
  AST_CONV_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    done && !rc_sel_r |-> conv_cyc == 8'(CONV_CYC - 1)) else $error("conversion length wrong");
  AST_RC_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(in_conv) && rc_sel_r |-> $past(state_r == ST_DELAY, 4)) else $error("rc start delay wrong");
  AST_SLEEP_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_abort && !wr_ctrl0 |=> !go_r && on_r ##1 !analog_enable)
    else $error("sleep abort wrong");
  AST_SLEEP_SHUT: assert property (@(posedge pclk) disable iff (!presetn)
    done && sleep_mode && rc_sel_r && !en_r[IRQ_DONE] |=> shut_r && on_r) else $error("no shutdown");
  AST_TRIG: assert property (@(posedge pclk) disable iff (!presetn)
    trig_start && !busy && !shut_r && !sleep_mode |=> go_r) else $error("trigger did not start");
  AST_TRIG_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    trig_edge[0] |=> stat_r[1]) else $error("trigger flag not set");

  COV_DONE: cover property (@(posedge pclk) disable iff (!presetn) done);
  COV_ABORT: cover property (@(posedge pclk) disable iff (!presetn) in_conv && sw_abort);
  COV_TRIG: cover property (@(posedge pclk) disable iff (!presetn) trig_start && !busy);
endmodule

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the converter control block
// Assumes: Zero-wait APB slave, 46-cycle conversion on the system clock
// Notes: Comparator held at one level per conversion, so results are all ones or zeros
`timescale 1ns/1ps
module tb_top;
  import adc_ctrl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [4:0] paddr, trig_src, channel_code;
  logic [9:0] trial_code;
  logic [31:0] pwdata, prdata, rd;
  logic rc_tick, sleep_mode, cmp_above, channel_connected, analog_enable, irq, wake_req;
  logic [1:0] rc_cnt;
  int failures, tests_run;

  adc_conversion_control u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_src(trig_src), .rc_tick(rc_tick), .sleep_mode(sleep_mode),
    .cmp_above(cmp_above), .trial_code(trial_code), .channel_code(channel_code),
    .channel_connected(channel_connected), .analog_enable(analog_enable), .irq(irq),
    .wake_req(wake_req));

  // Clock and an RC tick every third cycle, unrelated to APB traffic
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Tick generator owns its own state, so reset gives it a known start
  always @(posedge pclk) begin
    if (!presetn) begin
      rc_cnt <= 2'h0;
      rc_tick <= 1'b0;
    end else begin
      rc_cnt <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
      rc_tick <= (rc_cnt == 2'h0);
    end
  end

  // One comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // APB transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic [4:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp, input string what);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp, what);
  endtask

  // Bounded poll of the go bit; a hang shows up as a go mismatch later
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(OFF_CTRL0, 1'b0, 32'h0);
      n++;
    end while (rd[GO_BIT] !== 1'b0 && n < 80);
  endtask

  task automatic t_off();
    apb(OFF_CTRL2, 1'b1, {25'h0, TRIG_TIMER_ZERO, 4'h0});
    trig_src <= 5'h01;
    repeat (3) @(posedge pclk);
    trig_src <= 5'h00;
    apb(OFF_CTRL0, 1'b1, 32'h2);
    rdchk(OFF_CTRL0, 32'h0, "go while off");
    rdchk(OFF_RES_LO, 32'h0, "result while off");
    apb(OFF_CTRL0, 1'b1, 32'h3);
    rdchk(OFF_CTRL0, 32'h1, "go in enabling write");
    apb(OFF_IRQ_CLR, 1'b1, 32'h3F);
    apb(5'h02, 1'b1, 32'h0);
    chk({31'h0, err}, 32'h1, "misaligned");
    rdchk(OFF_IRQ_CLR, 32'h0, "clear reads zero");
    $display("test off done");
  endtask

  task automatic t_conv();
    cmp_above <= 1'b1;
    apb(OFF_IRQ_EN, 1'b1, 32'h1);
    apb(OFF_CTRL0, 1'b1, 32'h0F);
    repeat (38) @(posedge pclk);
    rdchk(OFF_CTRL0, 32'h0F, "busy before 46");
    repeat (8) @(posedge pclk);
    rdchk(OFF_CTRL0, 32'h0D, "go cleared");
    rdchk(OFF_RES_HI, 32'h3, "result high");
    rdchk(OFF_RES_LO, 32'hFF, "result low");
    rdchk(OFF_IRQ_STAT, 32'h1, "done flag");
    repeat (2) @(negedge pclk);
    chk({22'h0, trial_code}, 32'h3FF, "trial code");
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(OFF_IRQ_EN, 1'b1, 32'h0);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    apb(OFF_IRQ_CLR, 1'b1, 32'h1);
    rdchk(OFF_IRQ_STAT, 32'h0, "done cleared");
    $display("test conv done");
  endtask

  task automatic t_abort();
    cmp_above <= 1'b0;
    apb(OFF_CTRL0, 1'b1, 32'h0F);
    repeat (20) @(posedge pclk);
    apb(OFF_CTRL0, 1'b1, 32'h0D);
    repeat (2) @(posedge pclk);
    rdchk(OFF_CTRL0, 32'h0D, "aborted");
    rdchk(OFF_RES_HI, 32'h0, "partial high");
    rdchk(OFF_RES_LO, 32'h0, "partial low");
    $display("test abort done");
  endtask

  task automatic t_trig();
    for (int k = 0; k < 5; k++) begin
      apb(OFF_CTRL2, 1'b1, 32'(k + 3) << TRIG_LSB);
      trig_src <= 5'(1 << k);
      repeat (4) @(posedge pclk);
      trig_src <= 5'h00;
      rdchk(OFF_CTRL0, 32'h0F, "trigger sets go");
      apb(OFF_IRQ_STAT, 1'b0, 32'h0);
      chk(rd & 32'h3E, 32'(2 << k), "source flag");
      wait_idle();
      apb(OFF_IRQ_CLR, 1'b1, 32'h3F);
    end
    apb(OFF_CTRL2, 1'b1, {25'h0, TRIG_NONE, 4'h0});
    trig_src <= 5'h1F;
    repeat (4) @(posedge pclk);
    trig_src <= 5'h00;
    rdchk(OFF_CTRL0, 32'h0D, "no source selected");
    rdchk(OFF_IRQ_STAT, 32'h3E, "all source flags");
    apb(OFF_IRQ_CLR, 1'b1, 32'h3F);
    $display("test trigger done");
  endtask

  task automatic t_chan();
    logic exp;
    for (int c = 0; c < 32; c++) begin
      exp = (c >= CHAN_EXT_FIRST && c <= CHAN_EXT_LAST) || c >= CHAN_TEMP;
      apb(OFF_CTRL0, 1'b1, 32'(c << CHAN_LSB) | 32'h1);
      repeat (2) @(negedge pclk);
      chk({27'h0, channel_code}, 32'(c), "channel code");
      chk({31'h0, channel_connected}, {31'h0, exp}, "channel valid");
    end
    $display("test channel done");
  endtask

  task automatic t_sleep();
    apb(OFF_CTRL0, 1'b1, 32'h0F);
    repeat (10) @(posedge pclk);
    sleep_mode <= 1'b1;
    repeat (4) @(negedge pclk);
    chk({31'h0, analog_enable}, 32'h0, "sleep shuts off");
    apb(OFF_CTRL0, 1'b0, 32'h0);
    chk(rd & 32'h1, 32'h1, "on bit kept");
    sleep_mode <= 1'b0;
    apb(OFF_CTRL0, 1'b1, 32'h0);
    apb(OFF_CLKCFG, 1'b1, 32'h1);
    apb(OFF_IRQ_EN, 1'b1, 32'h1);
    apb(OFF_CTRL0, 1'b1, 32'h0D);
    cmp_above <= 1'b1;
    sleep_mode <= 1'b1;
    apb(OFF_CTRL0, 1'b1, 32'h0F);
    wait_idle();
    rdchk(OFF_RES_LO, 32'hFF, "rc result");
    repeat (2) @(negedge pclk);
    chk({31'h0, wake_req}, 32'h1, "wake on done");
    apb(OFF_IRQ_CLR, 1'b1, 32'h1);
    apb(OFF_IRQ_EN, 1'b1, 32'h0);
    apb(OFF_CTRL0, 1'b1, 32'h0F);
    wait_idle();
    repeat (2) @(negedge pclk);
    chk({31'h0, analog_enable}, 32'h0, "off after done");
    chk(rd & 32'h1, 32'h1, "on bit stays");
    $display("test sleep done");
  endtask

  // Reset in mid-conversion must cancel it and clear the control, clock and result registers
  task automatic t_midreset();
    sleep_mode <= 1'b0;
    apb(OFF_CTRL0, 1'b1, 32'h0D);
    apb(OFF_CTRL0, 1'b1, 32'h0F);
    repeat (10) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFF_CTRL0, 32'h0, "ctrl0 reset");
    rdchk(OFF_CLKCFG, 32'h0, "clock reset");
    rdchk(OFF_RES_LO, 32'h0, "result reset");
    chk({31'h0, analog_enable}, 32'h0, "module off");
    $display("test reset done");
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    failures = 0;
    tests_run = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, err} = 4'h0;
    paddr = 5'h00;
    pwdata = 32'h0;
    trig_src = 5'h00;
    {sleep_mode, cmp_above} = 2'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFF_CTRL0, 32'h0, "ctrl0 at start");
    rdchk(OFF_IRQ_STAT, 32'h0, "status at start");
    t_off();
    t_conv();
    t_abort();
    t_trig();
    t_chan();
    t_sleep();
    t_midreset();
    summarize();
  end

  // Watchdog, well beyond the thousand or so cycles the tests need
  initial begin
    #200000;
    failures++;
    summarize();
  end
endmodule
